// >>> sss_pkg.sv
`default_nettype none
package sss_pkg;
    // Register indexes on the plain register port
    localparam logic [3:0] ADDR_TX_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RX_CTRL = 4'h1;
    localparam logic [3:0] ADDR_RX_DATA = 4'h2;
    localparam logic [3:0] ADDR_TX_DATA = 4'h3;
    localparam logic [3:0] ADDR_FLAGS = 4'h4;
    localparam logic [3:0] ADDR_PIE = 4'h5;
    localparam logic [3:0] ADDR_IRQ_CTRL = 4'h6;
    localparam logic [3:0] ADDR_EV_STAT = 4'h7;
    localparam logic [3:0] ADDR_EV_MASK = 4'h8;
    // Field positions
    localparam int TXC_CLK_SRC = 7;
    localparam int TXC_TXEN = 5;
    localparam int TXC_SYNC = 4;
    localparam int TXC_TRMT = 1;
    localparam int RXC_SPEN = 7;
    localparam int RXC_SINGLE_RX = 5;
    localparam int RXC_CONT_RX = 4;
    localparam int RXC_OERR = 1;
    localparam int FLG_RX_DONE = 5;
    localparam int FLG_TX_EMPTY = 4;
    localparam int PIE_RX = 5;
    localparam int PIE_TX = 4;
    localparam int IC_GLOBAL_EN = 7;
    localparam int IC_PERIPH_EN = 6;
    localparam int EV_RX = 0;
    localparam int EV_TX = 1;
    localparam int EV_OVR = 2;
    // Sizes, reset values and timing
    localparam int WORD_BITS = 8;
    localparam int RX_DEPTH = 2;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] EV_RESET = 3'h0;
    localparam logic [13:0] ISR_VECTOR = 14'h0004;
    localparam int CLK_NS = 50;
    localparam int MASTER_HALF_NS = 200;
    localparam int MASTER_HALF_CYC = (MASTER_HALF_NS / CLK_NS) < 1 ? 1 : (MASTER_HALF_NS / CLK_NS);

    typedef struct packed {
        logic clock_source_select;
        logic txen;
        logic sync;
        logic spen;
        logic single_receive_enable;
        logic continuous_receive_enable;
    } sss_ctrl_t;

    typedef enum logic [2:0] {
        WK_RUN = 3'h1,
        WK_NEXT = 3'h2,
        WK_VECTOR = 3'h4
    } sss_wake_state_t;
endpackage : sss_pkg
`default_nettype wire

// >>> sss_sync3.sv
`default_nettype none
module sss_sync3 #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Asynchronous levels in, filtered levels out
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            s1 <= async_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change counts once the second and third stages agree
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        always_ff @(posedge sys_clk_i)
        begin
            if (!resetn_i)
                level_o[i] <= 1'b0;
            else if (s2[i] == s3[i])
                level_o[i] <= s3[i];
        end
    end
endmodule : sss_sync3
`default_nettype wire

// >>> sss_wake.sv
`default_nettype none
module sss_wake (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Processor state and requests
    input wire logic sleep_i,
    input wire logic wake_req_i,
    input wire logic global_en_i,
    // Wake sequence
    output logic wake_o,
    output logic resume_o,
    output logic isr_req_o,
    output logic [13:0] isr_addr_o
);
    sss_pkg::sss_wake_state_t state;

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            state <= sss_pkg::WK_RUN;
            wake_o <= 1'b0;
            resume_o <= 1'b0;
            isr_req_o <= 1'b0;
            isr_addr_o <= 14'h0000;
        end
        else
        begin
            wake_o <= 1'b0;
            resume_o <= 1'b0;
            isr_req_o <= 1'b0;
            case (state)
                sss_pkg::WK_RUN:
                begin
                    if (sleep_i && wake_req_i)
                    begin
                        wake_o <= 1'b1;
                        state <= sss_pkg::WK_NEXT;
                    end
                end
                sss_pkg::WK_NEXT:
                begin
                    // Instruction after the sleep runs first
                    resume_o <= 1'b1;
                    state <= global_en_i ? sss_pkg::WK_VECTOR : sss_pkg::WK_RUN;
                end
                sss_pkg::WK_VECTOR:
                begin
                    isr_req_o <= 1'b1;
                    isr_addr_o <= sss_pkg::ISR_VECTOR;
                    state <= sss_pkg::WK_RUN;
                end
                default: state <= sss_pkg::WK_RUN;
            endcase
        end
    end

    chk_wake_sequence: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (state == sss_pkg::WK_RUN && sleep_i && wake_req_i) |=> wake_o ##1 resume_o)
        else $error("wake request did not start the wake sequence");
    chk_vector_after_next: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (state == sss_pkg::WK_NEXT && global_en_i) |=> ##1 (isr_req_o && isr_addr_o == sss_pkg::ISR_VECTOR))
        else $error("vector call missing after resume");
endmodule : sss_wake
`default_nettype wire

// >>> sss_port.sv
// Summary of operation
// - Sleep shifting continues only in slave mode
// - Master and async shifting need system clock
// - Slave shifters clocked only by pin clock
// - Data read pops buffer; flag clears empty
// - Slave receiver samples data on pin clock
// - Full received word sets flag, wakes core
// - Receive wake gated by receive enable
// - Resume next instruction, then vector if global
// - Transmit write clears empty flag, fills buffers
// - Slave transmitter drives data on pin clock
// - Word out: move pending byte, set flag
// - Buffer then takes another byte, clearing flag
// - Transmit wake needs transmit and peripheral enables
// - Sync select bit chooses synchronous operation
// - Cleared clock source makes port slave
// - Both receive enables clear with transmit enable set means transmitter
// - Completed word moves into receive data
`default_nettype none
module sss_port (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Processor power state
    input wire logic sleep_i,
    output logic wake_o,
    output logic resume_o,
    output logic isr_req_o,
    output logic [13:0] isr_addr_o,
    output logic irq_o,
    // Serial clock pin
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_o,
    // Serial data pin
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] target);
        hit = (addr == target);
    endfunction : hit

    sss_pkg::sss_ctrl_t ctrl;
    logic pie_rx;
    logic pie_tx;
    logic global_en;
    logic periph_en;
    logic [2:0] ev_stat;
    logic [2:0] ev_mask;
    logic [1:0] pin_q;
    logic clk_prev;
    logic mclk;
    logic [2:0] mcnt;
    logic [7:0] rx_shift;
    logic [2:0] rcnt;
    logic [7:0] rx_mem [sss_pkg::RX_DEPTH];
    logic rx_wp;
    logic rx_rp;
    logic [1:0] rx_cnt;
    logic oerr;
    logic [7:0] tbuf;
    logic tbuf_full;
    logic [7:0] tx_shift;
    logic [2:0] tcnt;
    logic tx_shift_busy;
    logic wake_req_q;
    localparam logic [7:0] REG_ZERO = sss_pkg::REG_RESET;

    // Pin clock and data enter through three-stage filters
    sss_sync3 #(.W(2)) u_sync (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .async_i({serial_data_pin_i, serial_clock_pin_i}),
        .level_o(pin_q)
    );

    logic slave;
    logic master;
    logic run;
    logic rx_mode;
    logic tx_mode;
    logic m_tick;
    logic fall_ev;
    logic rx_done;
    logic push;
    logic pop;
    logic move;
    logic rx_flag;
    logic tx_flag;
    logic wr_tx;
    logic [7:0] next_rx_shift;
    logic [7:0] next_rdata;

    assign slave = ctrl.spen && ctrl.sync && !ctrl.clock_source_select;
    assign master = ctrl.spen && ctrl.sync && ctrl.clock_source_select;
    assign run = slave || (master && !sleep_i);
    assign rx_mode = ctrl.single_receive_enable || ctrl.continuous_receive_enable;
    assign tx_mode = !rx_mode && ctrl.txen;
    assign m_tick = (mcnt == 3'(sss_pkg::MASTER_HALF_CYC - 1));
    // Slave edges come only from the pin; master edges from the divider
    assign fall_ev = run && (slave ? (clk_prev && !pin_q[0]) : (m_tick && mclk));
    assign next_rx_shift = {pin_q[1], rx_shift[7:1]};
    assign rx_done = fall_ev && rx_mode && (rcnt == 3'h7);
    assign push = rx_done && (rx_cnt != 2'(sss_pkg::RX_DEPTH));
    assign wr_tx = reg_wr_i && hit(reg_addr_i, sss_pkg::ADDR_TX_DATA);
    assign pop = reg_rd_i && hit(reg_addr_i, sss_pkg::ADDR_RX_DATA) && (rx_cnt != 2'h0);
    assign move = tbuf_full && !tx_shift_busy;
    assign rx_flag = (rx_cnt != 2'h0);
    assign tx_flag = !tbuf_full;

    // Control registers
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            ctrl <= '0;
            pie_rx <= 1'b0;
            pie_tx <= 1'b0;
            global_en <= 1'b0;
            periph_en <= 1'b0;
            ev_mask <= sss_pkg::EV_RESET;
        end
        else if (reg_wr_i)
        begin
            if (hit(reg_addr_i, sss_pkg::ADDR_TX_CTRL))
            begin
                ctrl.clock_source_select <= reg_wdata_i[sss_pkg::TXC_CLK_SRC];
                ctrl.txen <= reg_wdata_i[sss_pkg::TXC_TXEN];
                ctrl.sync <= reg_wdata_i[sss_pkg::TXC_SYNC];
            end
            if (hit(reg_addr_i, sss_pkg::ADDR_RX_CTRL))
            begin
                ctrl.spen <= reg_wdata_i[sss_pkg::RXC_SPEN];
                ctrl.single_receive_enable <= reg_wdata_i[sss_pkg::RXC_SINGLE_RX];
                ctrl.continuous_receive_enable <= reg_wdata_i[sss_pkg::RXC_CONT_RX];
            end
            if (hit(reg_addr_i, sss_pkg::ADDR_PIE))
            begin
                pie_rx <= reg_wdata_i[sss_pkg::PIE_RX];
                pie_tx <= reg_wdata_i[sss_pkg::PIE_TX];
            end
            if (hit(reg_addr_i, sss_pkg::ADDR_IRQ_CTRL))
            begin
                global_en <= reg_wdata_i[sss_pkg::IC_GLOBAL_EN];
                periph_en <= reg_wdata_i[sss_pkg::IC_PERIPH_EN];
            end
            if (hit(reg_addr_i, sss_pkg::ADDR_EV_MASK))
                ev_mask <= reg_wdata_i[2:0];
        end
    end

    // Master clock divider and pin edge history
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i || !master)
        begin
            mcnt <= 3'h0;
            mclk <= 1'b0;
        end
        else if (!sleep_i)
        begin
            mcnt <= m_tick ? 3'h0 : mcnt + 3'h1;
            if (m_tick)
                mclk <= !mclk;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            clk_prev <= 1'b0;
        else
            clk_prev <= pin_q[0];
    end

    // Receive shifter samples the data pin on falling clock edges
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i || !ctrl.spen || !rx_mode)
        begin
            rx_shift <= REG_ZERO;
            rcnt <= 3'h0;
        end
        else if (fall_ev)
        begin
            rx_shift <= next_rx_shift;
            rcnt <= rcnt + 3'h1;
        end
    end

    // Two-entry receive buffer; a word arriving when full is an overrun
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i || !ctrl.spen)
        begin
            rx_wp <= 1'b0;
            rx_rp <= 1'b0;
            rx_cnt <= 2'h0;
            for (int i = 0; i < sss_pkg::RX_DEPTH; i++)
                rx_mem[i] <= REG_ZERO;
        end
        else
        begin
            if (push)
            begin
                rx_mem[rx_wp] <= next_rx_shift;
                rx_wp <= !rx_wp;
            end
            if (pop)
                rx_rp <= !rx_rp;
            rx_cnt <= rx_cnt + 2'(push) - 2'(pop);
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i || !ctrl.spen || !ctrl.continuous_receive_enable)
            oerr <= 1'b0;
        else if (rx_done && !push)
            oerr <= 1'b1;
    end

    // Transmit buffer: a write fills it, the shifter drains it
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i || !ctrl.spen)
        begin
            tbuf <= REG_ZERO;
            tbuf_full <= 1'b0;
        end
        else if (wr_tx)
        begin
            tbuf <= reg_wdata_i;
            tbuf_full <= 1'b1;
        end
        else if (move)
            tbuf_full <= 1'b0;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i || !ctrl.spen)
        begin
            tx_shift <= REG_ZERO;
            tcnt <= 3'h0;
            tx_shift_busy <= 1'b0;
        end
        else if (move)
        begin
            tx_shift <= tbuf;
            tcnt <= 3'h0;
            tx_shift_busy <= 1'b1;
        end
        else if (fall_ev && tx_mode && tx_shift_busy)
        begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tcnt <= tcnt + 3'h1;
            if (tcnt == 3'h7)
                tx_shift_busy <= 1'b0;
        end
    end

    // Pin drivers
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            serial_clock_pin_o <= 1'b0;
            serial_clock_pin_oe_o <= 1'b0;
            serial_data_pin_o <= 1'b0;
            serial_data_pin_oe_o <= 1'b0;
        end
        else
        begin
            serial_clock_pin_o <= mclk;
            serial_clock_pin_oe_o <= master;
            serial_data_pin_o <= tx_shift[0];
            serial_data_pin_oe_o <= ctrl.spen && ctrl.sync && tx_mode;
        end
    end

    // Sticky events, write one to clear; a new event beats the clear
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            ev_stat <= sss_pkg::EV_RESET;
            irq_o <= 1'b0;
        end
        else
        begin
            ev_stat <= (ev_stat & ~((reg_wr_i && hit(reg_addr_i, sss_pkg::ADDR_EV_STAT)) ? reg_wdata_i[2:0] : 3'h0))
                | {rx_done && !push, move, push};
            irq_o <= |(ev_stat & ev_mask);
        end
    end

    // Wake request registered before it enters the wake sequencer
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            wake_req_q <= 1'b0;
        else
            wake_req_q <= (rx_flag && pie_rx) || (tx_flag && pie_tx && periph_en);
    end

    sss_wake u_wake (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .sleep_i(sleep_i),
        .wake_req_i(wake_req_q),
        .global_en_i(global_en),
        .wake_o(wake_o),
        .resume_o(resume_o),
        .isr_req_o(isr_req_o),
        .isr_addr_o(isr_addr_o)
    );

    // Register read, data valid one cycle after the strobe
    always_comb
    begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            sss_pkg::ADDR_TX_CTRL:
                next_rdata = (8'(ctrl.clock_source_select) << sss_pkg::TXC_CLK_SRC)
                    | (8'(ctrl.txen) << sss_pkg::TXC_TXEN) | (8'(ctrl.sync) << sss_pkg::TXC_SYNC)
                    | (8'(!tx_shift_busy) << sss_pkg::TXC_TRMT);
            sss_pkg::ADDR_RX_CTRL:
                next_rdata = (8'(ctrl.spen) << sss_pkg::RXC_SPEN)
                    | (8'(ctrl.single_receive_enable) << sss_pkg::RXC_SINGLE_RX)
                    | (8'(ctrl.continuous_receive_enable) << sss_pkg::RXC_CONT_RX) | (8'(oerr) << sss_pkg::RXC_OERR);
            sss_pkg::ADDR_RX_DATA: next_rdata = rx_mem[rx_rp];
            sss_pkg::ADDR_FLAGS:
                next_rdata = (8'(rx_flag) << sss_pkg::FLG_RX_DONE) | (8'(tx_flag) << sss_pkg::FLG_TX_EMPTY);
            sss_pkg::ADDR_PIE: next_rdata = (8'(pie_rx) << sss_pkg::PIE_RX) | (8'(pie_tx) << sss_pkg::PIE_TX);
            sss_pkg::ADDR_IRQ_CTRL:
                next_rdata = (8'(global_en) << sss_pkg::IC_GLOBAL_EN) | (8'(periph_en) << sss_pkg::IC_PERIPH_EN);
            sss_pkg::ADDR_EV_STAT: next_rdata = {5'h00, ev_stat};
            sss_pkg::ADDR_EV_MASK: next_rdata = {5'h00, ev_mask};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            reg_rdata_o <= 8'h00;
        else
            reg_rdata_o <= reg_rd_i ? next_rdata : 8'h00;
    end

    chk_master_sleep_halt: assert property ((master && sleep_i && rx_mode) |=> $stable(rcnt))
        else $error("master receiver shifted during sleep");
    chk_slave_pin_clock: assert property ((slave && rx_mode && !(clk_prev && !pin_q[0])) |=> $stable(rx_shift))
        else $error("slave receiver moved without a pin clock edge");
    chk_rx_pop_clear: assert property ((pop && rx_cnt == 2'h1 && !rx_done) |=> !rx_flag)
        else $error("receive flag stayed set after the last word was read");
    chk_rx_word_land: assert property ((push && !pop && rx_cnt == 2'h0)
        |=> (rx_flag && rx_mem[$past(rx_wp)] == $past(next_rx_shift)))
        else $error("received word not transferred to the data register");
    chk_tx_write_clear: assert property ((wr_tx && ctrl.spen) |=> !tx_flag)
        else $error("transmit write did not clear the empty flag");
    chk_tx_move_set: assert property ((move && !wr_tx)
        |=> (tx_flag && tx_shift_busy && tx_shift == $past(tbuf)))
        else $error("pending byte not moved into the shifter");
    chk_rx_wake_req: assert property ((rx_flag && pie_rx) |=> wake_req_q)
        else $error("receive wake request missing");
    chk_tx_wake_gate: assert property ((tx_flag && pie_tx && !periph_en && !(rx_flag && pie_rx)) |=> !wake_req_q)
        else $error("transmit wake raised without the peripheral enable");
endmodule : sss_port
`default_nettype wire

// >>> sss_master_model.sv
`default_nettype none
module sss_master_model (
    // Design side of the pins
    input wire logic dut_clk_i,
    input wire logic dut_clk_oe_i,
    input wire logic dut_data_i,
    input wire logic dut_data_oe_i,
    // Resolved pin levels
    output logic clk_pin_o,
    output logic data_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic m_clk = 1'b0;
    logic m_drv = 1'b0;
    logic m_d = 1'b0;
    logic idle_v = 1'b0;
    // Master owns the pin clock, low between frames
    assign clk_pin_o = dut_clk_oe_i ? dut_clk_i : m_clk;
    // A released line shows the inverse of its last level
    assign data_pin_o = dut_data_oe_i ? dut_data_i : (m_drv ? m_d : idle_v);
    always @(negedge dut_data_oe_i)
    begin
        idle_v = ~dut_data_i;
    end
    // One word LSB first: change on rising edge, sample on falling edge
    task automatic xfer(input logic [7:0] tx, input logic drive, input int half_ns, output logic [7:0] rx);
        for (int i = 0; i < 8; i++)
        begin
            m_d = tx[i];
            m_drv = drive;
            m_clk = 1'b1;
            #(half_ns);
            m_clk = 1'b0;
            rx[i] = data_pin_o;
            #(half_ns);
        end
        idle_v = ~m_d;
        m_drv = 1'b0;
    endtask : xfer
endmodule : sss_master_model
`default_nettype wire

// >>> sss_port_bench.sv
`default_nettype none
module sss_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sleep = 1'b0;
    logic exp_isr = 1'b0;
    logic w1 = 1'b0;
    logic w2 = 1'b0;
    logic [7:0] rdata;
    logic [7:0] v;
    logic [13:0] isr_addr;
    logic wake, resume, isr_req, irq, ck_pin, ck_o, ck_oe, dt_pin, dt_o, dt_oe;
    int fails = 0;
    int n_checks = 0;
    int n_wake = 0;
    int cyc = 0;
    int base = 0;

    always #25 sys_clk = ~sys_clk;

    sss_port dut_u (
        .sys_clk_i(sys_clk), .resetn_i(resetn),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .sleep_i(sleep), .wake_o(wake), .resume_o(resume), .isr_req_o(isr_req), .isr_addr_o(isr_addr),
        .irq_o(irq),
        .serial_clock_pin_i(ck_pin), .serial_clock_pin_o(ck_o), .serial_clock_pin_oe_o(ck_oe),
        .serial_data_pin_i(dt_pin), .serial_data_pin_o(dt_o), .serial_data_pin_oe_o(dt_oe)
    );

    sss_master_model master_u (
        .dut_clk_i(ck_o), .dut_clk_oe_i(ck_oe), .dut_data_i(dt_o), .dut_data_oe_i(dt_oe),
        .clk_pin_o(ck_pin), .data_pin_o(dt_pin)
    );

    task automatic print_verdict();
        if (fails == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read, then compare the masked value
    task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk(what, {8'h00, e}, {8'h00, rdata & m});
    endtask : rchk

    task automatic wait_wake();
        for (int k = 0; k < 400 && n_wake == base; k++)
            @(posedge sys_clk);
        chk("wake", 16'h0001, {15'h0000, n_wake > base});
    endtask : wait_wake

    // Wake sequence monitor and timeout
    always @(posedge sys_clk)
    begin
        cyc++;
        if (wake === 1'b1)
            n_wake++;
        if (w1 === 1'b1)
            chk("resume", 16'h0001, {15'h0000, resume});
        if (w2 === 1'b1)
            chk("isr_req", {15'h0000, exp_isr}, {15'h0000, isr_req});
        w1 <= wake;
        w2 <= w1;
        if (cyc == 4000)
        begin
            fails++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        rchk("unmapped", 4'hF, 8'hFF, 8'h00);
        rchk("enable reset", sss_pkg::ADDR_PIE, 8'hFF, 8'h00);
        // Receive during sleep with vector
        wr_reg(sss_pkg::ADDR_TX_CTRL, 8'h10);
        wr_reg(sss_pkg::ADDR_RX_CTRL, 8'h90);
        wr_reg(sss_pkg::ADDR_PIE, 8'h20);
        wr_reg(sss_pkg::ADDR_IRQ_CTRL, 8'hC0);
        wr_reg(sss_pkg::ADDR_EV_MASK, 8'h01);
        chk("clock oe slave", 16'h0000, {15'h0000, ck_oe});
        chk("data oe rx", 16'h0000, {15'h0000, dt_oe});
        exp_isr = 1'b1;
        @(posedge sys_clk);
        sleep <= 1'b1;
        base = n_wake;
        master_u.xfer(8'hA5, 1'b1, 200, v);
        wait_wake();
        repeat (3) @(posedge sys_clk);
        chk("isr addr", {2'b00, sss_pkg::ISR_VECTOR}, {2'b00, isr_addr});
        chk("irq", 16'h0001, {15'h0000, irq});
        sleep <= 1'b0;
        rchk("rx flag", sss_pkg::ADDR_FLAGS, 8'h20, 8'h20);
        rchk("rx data", sss_pkg::ADDR_RX_DATA, 8'hFF, 8'hA5);
        rchk("rx flag clear", sss_pkg::ADDR_FLAGS, 8'h20, 8'h00);
        wr_reg(sss_pkg::ADDR_EV_STAT, 8'h01);
        repeat (3) @(posedge sys_clk);
        chk("irq clear", 16'h0000, {15'h0000, irq});
        // Three words with two buffered
        for (int i = 1; i < 4; i++)
            master_u.xfer(8'(i * 17), 1'b1, 200, v);
        rchk("overrun", sss_pkg::ADDR_RX_CTRL, 8'h02, 8'h02);
        rchk("events", sss_pkg::ADDR_EV_STAT, 8'h05, 8'h05);
        rchk("rx first", sss_pkg::ADDR_RX_DATA, 8'hFF, 8'h11);
        rchk("rx second", sss_pkg::ADDR_RX_DATA, 8'hFF, 8'h22);
        rchk("rx empty", sss_pkg::ADDR_FLAGS, 8'h20, 8'h00);
        wr_reg(sss_pkg::ADDR_RX_CTRL, 8'h80);
        rchk("overrun clear", sss_pkg::ADDR_RX_CTRL, 8'h02, 8'h00);
        // Transmit wake blocked without peripheral enable
        wr_reg(sss_pkg::ADDR_TX_CTRL, 8'h30);
        wr_reg(sss_pkg::ADDR_PIE, 8'h10);
        wr_reg(sss_pkg::ADDR_IRQ_CTRL, 8'h80);
        chk("data oe tx", 16'h0001, {15'h0000, dt_oe});
        rchk("tx empty", sss_pkg::ADDR_FLAGS, 8'h10, 8'h10);
        @(posedge sys_clk);
        sleep <= 1'b1;
        base = n_wake;
        repeat (20) @(posedge sys_clk);
        chk("no tx wake", 16'(base), 16'(n_wake));
        sleep <= 1'b0;
        // Transmit during sleep, wake without vector
        wr_reg(sss_pkg::ADDR_IRQ_CTRL, 8'h40);
        exp_isr = 1'b0;
        wr_reg(sss_pkg::ADDR_TX_DATA, 8'h3C);
        wr_reg(sss_pkg::ADDR_TX_DATA, 8'hC3);
        rchk("tx full", sss_pkg::ADDR_FLAGS, 8'h10, 8'h00);
        @(posedge sys_clk);
        sleep <= 1'b1;
        base = n_wake;
        master_u.xfer(8'h00, 1'b0, 200, v);
        chk("tx word1", 16'h003C, {8'h00, v});
        wait_wake();
        repeat (3) @(posedge sys_clk);
        sleep <= 1'b0;
        rchk("tx moved", sss_pkg::ADDR_FLAGS, 8'h10, 8'h10);
        wr_reg(sss_pkg::ADDR_TX_DATA, 8'h5A);
        rchk("tx refill", sss_pkg::ADDR_FLAGS, 8'h10, 8'h00);
        master_u.xfer(8'h00, 1'b0, 200, v);
        chk("tx word2", 16'h00C3, {8'h00, v});
        master_u.xfer(8'h00, 1'b0, 200, v);
        chk("tx word3", 16'h005A, {8'h00, v});
        // Master mode drives the pin clock
        wr_reg(sss_pkg::ADDR_TX_CTRL, 8'hB0);
        repeat (2) @(posedge sys_clk);
        chk("clock oe master", 16'h0001, {15'h0000, ck_oe});
        // Master receiver must not complete a word while asleep
        wr_reg(sss_pkg::ADDR_RX_CTRL, 8'h90);
        @(posedge sys_clk);
        sleep <= 1'b1;
        repeat (80) @(posedge sys_clk);
        sleep <= 1'b0;
        rchk("master sleep idle", sss_pkg::ADDR_FLAGS, 8'h20, 8'h00);
        print_verdict();
    end
endmodule : sss_port_bench
`default_nettype wire
